// *** rtl/tto_front.sv ***
/*
  Trigger front end and output run of one pulse timer, with a classic
  Wishbone register slave.
  Assumes all inputs synchronous to clk; the other timers' outputs come
  in as one vector indexed by timer number, this timer's own bit included.
*/
// Our own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tto_params.svh"

module tto_front
  import tto_pkg::*;
#(
  parameter int NUM_LINES = 20,
  parameter int NUM_TIMERS = 4,
  parameter logic [1:0] OWN_TIMER = 2'h0,
  parameter int PW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // trigger origins
  input wire logic [NUM_LINES-1:0] io_line_inputs,
  input wire logic [NUM_LINES-1:0] io_line_is_output,
  input wire logic encoder_pulse_a,
  input wire logic encoder_pulse_b,
  input wire logic [NUM_TIMERS-1:0] other_timer_outputs,
  // timer result
  output logic timer_out,
  output logic run_active
);

  // ----------------------------------------
  // constants
  // ----------------------------------------
  localparam int STEP_CYC_INT = `TTO_STEP_NS / `TTO_CLK_NS;
  localparam logic [7:0] STEP_CYC = 8'(STEP_CYC_INT);
  localparam logic [4:0] LINE_LIM = 5'(NUM_LINES);
  localparam logic [31:0] TALLY_MAX = 32'hffffffff;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic gate;
    tto_policy_type policy;
    logic cnt_en;
    tto_origin_type origin;
    logic [4:0] idx;
    tto_polarity_type polar;
    logic [7:0] ratio;
    logic [3:0][PW-1:0] len;
    logic sw_trig;
    logic tally_clr;
    logic [31:0] tally;
    tto_run_type st;
    logic [7:0] cyc;
    logic [PW-1:0] steps;
    logic pending;
    logic out;
    logic ack;
    logic [31:0] dat;
  } tto_main_state_type;

  tto_main_state_type s_reg, s_next;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] widen(input logic [PW-1:0] v);
    logic [31:0] r;
    r = '0;
    r[PW-1:0] = v;
    return r;
  endfunction

  logic [31:0] ctrl_word;
  logic [31:0] origin_word;
  logic [31:0] status_word;

  always_comb begin
    ctrl_word = '0;
    ctrl_word[`TTO_CTRL_GATE] = s_reg.gate;
    ctrl_word[`TTO_CTRL_POL_LO +: 2] = s_reg.policy;
    ctrl_word[`TTO_CTRL_CNT_EN] = s_reg.cnt_en;
    origin_word = '0;
    origin_word[`TTO_ORG_KIND_LO +: 3] = s_reg.origin;
    origin_word[`TTO_ORG_IDX_LO +: 5] = s_reg.idx;
    origin_word[`TTO_ORG_POLAR_LO +: 3] = s_reg.polar;
    status_word = '0;
    status_word[0] = s_reg.st != ST_IDLE;
    status_word[1] = s_reg.pending;
    status_word[2] = s_reg.out;
    status_word[7:3] = s_reg.st;
  end

  // ----------------------------------------
  // origin selection
  // ----------------------------------------
  logic raw_sig;
  tto_polarity_type eff_polar;
  logic is_level;

  always_comb begin
    raw_sig = 1'b0;
    eff_polar = s_reg.polar;
    case (s_reg.origin)
      ORG_LINE: begin
        // a line driven as output looks like a constant low trigger
        if (s_reg.idx < LINE_LIM) begin
          raw_sig = io_line_inputs[s_reg.idx] &
                    ~io_line_is_output[s_reg.idx];
        end
      end
      ORG_ENC_A: begin
        raw_sig = encoder_pulse_a;
        eff_polar = ACT_UP;
      end
      ORG_ENC_B: begin
        raw_sig = encoder_pulse_b;
        eff_polar = ACT_UP;
      end
      ORG_TIMER: begin
        raw_sig = other_timer_outputs[s_reg.idx[1:0]];
      end
      default: begin
        raw_sig = 1'b0;
      end
    endcase
    is_level = (s_reg.origin == ORG_LINE || s_reg.origin == ORG_TIMER) &&
               (eff_polar == ACT_HIGH || eff_polar == ACT_LOW);
  end

  logic q_edge;
  logic q_level;
  logic div_edge;
  logic trig;

  tto_trig_qual u_qual (
    .clk(clk),
    .rstn(rstn),
    .sig(raw_sig),
    .polarity(eff_polar),
    .edge_pulse(q_edge),
    .level_act(q_level)
  );

  // software trigger bypasses activation and enters as an edge
  assign div_edge = (s_reg.origin == ORG_SOFT) ? s_reg.sw_trig :
                    (q_edge & ~is_level);

  tto_prescale u_div (
    .clk(clk),
    .rstn(rstn),
    .clear(~s_reg.gate),
    .ratio(s_reg.ratio),
    .edge_in(div_edge),
    .tick(trig)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic active;
  logic free_run;
  logic lvl;
  logic [PW-1:0] cur_len;
  logic step_end;
  logic done;
  logic last;
  logic start;
  logic drop;
  logic wr;
  logic [31:0] w;

  always_comb begin
    s_next = s_reg;
    s_next.sw_trig = 1'b0;
    s_next.tally_clr = 1'b0;
    start = 1'b0;
    drop = 1'b0;
    w = '0;
    active = s_reg.st != ST_IDLE;
    free_run = s_reg.origin == ORG_FREE;
    lvl = is_level & q_level;
    case (s_reg.st)
      ST_DLY0: cur_len = s_reg.len[0];
      ST_DUR0: cur_len = s_reg.len[1];
      ST_DLY1: cur_len = s_reg.len[2];
      default: cur_len = s_reg.len[3];
    endcase
    step_end = s_reg.cyc == STEP_CYC - 8'h01;
    done = active && (cur_len == '0 ||
           (step_end && s_reg.steps == cur_len - 1'b1));
    last = done && s_reg.st == ST_DUR1;

    // bus: ack one cycle after the request, write on the ack edge
    s_next.ack = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & s_reg.ack;
    if (s_next.ack) begin
      if (wb_adr_i == `TTO_OFS_CTRL) begin
        s_next.dat = ctrl_word;
      end else if (wb_adr_i == `TTO_OFS_ORIGIN) begin
        s_next.dat = origin_word;
      end else if (wb_adr_i == `TTO_OFS_PRESCALE) begin
        s_next.dat = {24'h000000, s_reg.ratio};
      end else if (wb_adr_i == `TTO_OFS_LEN0) begin
        s_next.dat = widen(s_reg.len[0]);
      end else if (wb_adr_i == `TTO_OFS_LEN1) begin
        s_next.dat = widen(s_reg.len[1]);
      end else if (wb_adr_i == `TTO_OFS_LEN2) begin
        s_next.dat = widen(s_reg.len[2]);
      end else if (wb_adr_i == `TTO_OFS_LEN3) begin
        s_next.dat = widen(s_reg.len[3]);
      end else if (wb_adr_i == `TTO_OFS_TALLY) begin
        s_next.dat = s_reg.tally;
      end else if (wb_adr_i == `TTO_OFS_STATUS) begin
        s_next.dat = status_word;
      end else begin
        s_next.dat = '0;
      end
    end
    if (wr) begin
      if (wb_adr_i == `TTO_OFS_CTRL) begin
        w = merge(ctrl_word, wb_dat_i, wb_sel_i);
        s_next.gate = w[`TTO_CTRL_GATE];
        if (w[`TTO_CTRL_POL_LO +: 2] <= 2'h2) begin
          s_next.policy = tto_policy_type'(w[`TTO_CTRL_POL_LO +: 2]);
        end
        s_next.cnt_en = w[`TTO_CTRL_CNT_EN];
      end else if (wb_adr_i == `TTO_OFS_ORIGIN) begin
        w = merge(origin_word, wb_dat_i, wb_sel_i);
        // own output as origin is refused: whole write is dropped
        if (!(w[`TTO_ORG_KIND_LO +: 3] == ORG_TIMER &&
              w[`TTO_ORG_IDX_LO +: 2] == OWN_TIMER) &&
            w[`TTO_ORG_KIND_LO +: 3] <= 3'h5 &&
            w[`TTO_ORG_POLAR_LO +: 3] <= 3'h4) begin
          s_next.origin = tto_origin_type'(w[`TTO_ORG_KIND_LO +: 3]);
          s_next.idx = w[`TTO_ORG_IDX_LO +: 5];
          s_next.polar = tto_polarity_type'(w[`TTO_ORG_POLAR_LO +: 3]);
        end
      end else if (wb_adr_i == `TTO_OFS_PRESCALE) begin
        if (wb_sel_i[0]) begin
          s_next.ratio = wb_dat_i[7:0];
        end
      end else if (wb_adr_i == `TTO_OFS_CMD) begin
        if (wb_sel_i[0]) begin
          s_next.sw_trig = wb_dat_i[`TTO_CMD_SW_TRIG];
          s_next.tally_clr = wb_dat_i[`TTO_CMD_TALLY_CLR];
        end
      end else if (wb_adr_i == `TTO_OFS_LEN0) begin
        s_next.len[0] = PW'(merge(widen(s_reg.len[0]), wb_dat_i,
                                  wb_sel_i));
      end else if (wb_adr_i == `TTO_OFS_LEN1) begin
        s_next.len[1] = PW'(merge(widen(s_reg.len[1]), wb_dat_i,
                                  wb_sel_i));
      end else if (wb_adr_i == `TTO_OFS_LEN2) begin
        s_next.len[2] = PW'(merge(widen(s_reg.len[2]), wb_dat_i,
                                  wb_sel_i));
      end else if (wb_adr_i == `TTO_OFS_LEN3) begin
        s_next.len[3] = PW'(merge(widen(s_reg.len[3]), wb_dat_i,
                                  wb_sel_i));
      end
    end

    // run control
    if (!s_reg.gate) begin
      s_next.st = ST_IDLE;
      s_next.pending = 1'b0;
    end else begin
      if (trig) begin
        if (!active || last) begin
          start = 1'b1;
        end else if (!free_run) begin
          case (s_reg.policy)
            POL_DISCARD: begin
              drop = 1'b1;
            end
            POL_LATCH: begin
              if (!s_reg.pending) begin
                s_next.pending = 1'b1;
              end else begin
                drop = 1'b1;
              end
            end
            default: begin
              start = 1'b1;
            end
          endcase
        end
      end
      if (last && !start) begin
        if (s_reg.pending) begin
          start = 1'b1;
          s_next.pending = 1'b0;
        end else if (free_run || lvl) begin
          start = 1'b1;
        end
      end else if (!active && (free_run || lvl)) begin
        start = 1'b1;
      end
    end

    // phase sequencing in microsecond steps
    if (s_reg.gate && start) begin
      s_next.st = ST_DLY0;
      s_next.cyc = 8'h00;
      s_next.steps = '0;
    end else if (!s_reg.gate) begin
      s_next.cyc = 8'h00;
      s_next.steps = '0;
    end else if (done) begin
      s_next.cyc = 8'h00;
      s_next.steps = '0;
      case (s_reg.st)
        ST_DLY0: s_next.st = ST_DUR0;
        ST_DUR0: s_next.st = ST_DLY1;
        ST_DLY1: s_next.st = ST_DUR1;
        default: s_next.st = ST_IDLE;
      endcase
    end else if (active) begin
      if (step_end) begin
        s_next.cyc = 8'h00;
        s_next.steps = s_reg.steps + 1'b1;
      end else begin
        s_next.cyc = s_reg.cyc + 8'h01;
      end
    end
    s_next.out = s_reg.gate &&
                 (s_next.st == ST_DUR0 || s_next.st == ST_DUR1);

    // dropped tally: a drop in the clear cycle still counts
    if (s_reg.tally_clr) begin
      s_next.tally = (drop && s_reg.cnt_en) ? 32'h00000001 :
                     32'h00000000;
    end else if (drop && s_reg.cnt_en && s_reg.tally != TALLY_MAX) begin
      s_next.tally = s_reg.tally + 32'h00000001;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.policy <= POL_DISCARD;
      s_reg.origin <= ORG_LINE;
      s_reg.polar <= ACT_UP;
      s_reg.ratio <= `TTO_RST_PRESCALE;
      s_reg.len <= {4{PW'(`TTO_RST_LEN)}};
      s_reg.st <= ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign wb_dat_o = s_reg.dat;
  assign wb_ack_o = s_reg.ack;
  assign timer_out = s_reg.out;
  assign run_active = s_reg.st != ST_IDLE;

endmodule

// *** rtl/tto_params.svh ***
/*
  Offsets, reset values and timing counts of the timer trigger front end.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef TTO_PARAMS_SVH
`define TTO_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TTO_OFS_CTRL 8'h00
`define TTO_OFS_ORIGIN 8'h04
`define TTO_OFS_PRESCALE 8'h08
`define TTO_OFS_CMD 8'h0c
`define TTO_OFS_LEN0 8'h10
`define TTO_OFS_LEN1 8'h14
`define TTO_OFS_LEN2 8'h18
`define TTO_OFS_LEN3 8'h1c
`define TTO_OFS_TALLY 8'h20
`define TTO_OFS_STATUS 8'h24

// ----------------------------------------
// field positions
// ----------------------------------------
`define TTO_CTRL_GATE 0
`define TTO_CTRL_POL_LO 1
`define TTO_CTRL_CNT_EN 3
`define TTO_ORG_KIND_LO 0
`define TTO_ORG_IDX_LO 8
`define TTO_ORG_POLAR_LO 16
`define TTO_CMD_SW_TRIG 0
`define TTO_CMD_TALLY_CLR 1

// ----------------------------------------
// reset values
// ----------------------------------------
`define TTO_RST_PRESCALE 8'h01
`define TTO_RST_LEN 16'h0001

// ----------------------------------------
// timing
// ----------------------------------------
`define TTO_STEP_NS 1000
`define TTO_CLK_NS 10

`endif

// *** rtl/tto_pkg.sv ***
/*
  Types shared by the timer trigger front end modules.
  Assumes tto_params.svh sits beside it.
*/
`include "tto_params.svh"

package tto_pkg;

  typedef enum logic [1:0] {
    POL_DISCARD = 2'h0,
    POL_LATCH = 2'h1,
    POL_RESTART = 2'h2
  } tto_policy_type;

  typedef enum logic [2:0] {
    ORG_LINE = 3'h0,
    ORG_FREE = 3'h1,
    ORG_ENC_A = 3'h2,
    ORG_ENC_B = 3'h3,
    ORG_SOFT = 3'h4,
    ORG_TIMER = 3'h5
  } tto_origin_type;

  typedef enum logic [2:0] {
    ACT_BOTH = 3'h0,
    ACT_DOWN = 3'h1,
    ACT_UP = 3'h2,
    ACT_HIGH = 3'h3,
    ACT_LOW = 3'h4
  } tto_polarity_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DLY0 = 5'h02,
    ST_DUR0 = 5'h04,
    ST_DLY1 = 5'h08,
    ST_DUR1 = 5'h10
  } tto_run_type;

endpackage

// *** rtl/tto_trig_qual.sv ***
/*
  Edge and level qualifier for the selected trigger origin.
  Assumes the input is synchronous to clk.
*/
`timescale 1ns/1ps

module tto_trig_qual
  import tto_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // origin signal
  input wire logic sig,
  input wire tto_polarity_type polarity,
  // qualified results
  output logic edge_pulse,
  output logic level_act
);

  typedef struct packed {
    logic primed;
    logic prev;
    logic edge_hit;
    logic level;
  } tto_qual_state_type;

  tto_qual_state_type s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.primed = 1'b1;
    s_next.prev = sig;
    s_next.edge_hit = 1'b0;
    // no edge on the first sample after reset
    if (s_reg.primed) begin
      case (polarity)
        ACT_BOTH: s_next.edge_hit = sig ^ s_reg.prev;
        ACT_DOWN: s_next.edge_hit = ~sig & s_reg.prev;
        ACT_UP: s_next.edge_hit = sig & ~s_reg.prev;
        default: s_next.edge_hit = 1'b0;
      endcase
    end
    s_next.level = (polarity == ACT_HIGH) ? sig :
                   (polarity == ACT_LOW) ? ~sig : 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign edge_pulse = s_reg.edge_hit;
  assign level_act = s_reg.level;

endmodule

// *** rtl/tto_prescale.sv ***
/*
  Edge prescaler: one output pulse for every ratio input edges.
  Assumes a ratio of zero is meant as one.
*/
`timescale 1ns/1ps

module tto_prescale (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic clear,
  input wire logic [7:0] ratio,
  // edges in, divided pulse out
  input wire logic edge_in,
  output logic tick
);

  typedef struct packed {
    logic [7:0] count;
    logic hit;
  } tto_div_state_type;

  tto_div_state_type s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.hit = 1'b0;
    if (clear) begin
      s_next.count = 8'h00;
    end else if (edge_in) begin
      if (s_reg.count + 8'h01 >= ratio) begin
        s_next.count = 8'h00;
        s_next.hit = 1'b1;
      end else begin
        s_next.count = s_reg.count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.hit;

endmodule

// *** testbench/tto_front_monitor.sv ***
/*
  Concurrent checks on the ports of tto_front, bound into it.
  Assumes one clock, clk, and a synchronous active-low rstn.
*/
`timescale 1ns/1ps

module tto_front_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // timer result
  input wire logic timer_out,
  input wire logic run_active
);
  // ----------------------------------------
  // bus handshake
  // ----------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_answer;
    @(posedge clk) disable iff (!rstn) s_req |=> s_ans;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("ack missing one cycle after a request");
  property p_ack_cause;
    @(posedge clk) disable iff (!rstn)
      $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without a request");
  property p_ack_one;
    @(posedge clk) disable iff (!rstn) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  property p_dat_hold;
    @(posedge clk) disable iff (!rstn) !wb_ack_o |-> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold)
    else $error("read data moved without ack");
  property p_reset_vals;
    @(posedge clk) disable iff (!rstn) $rose(rstn) |->
      !wb_ack_o && !run_active && !timer_out && wb_dat_o == 32'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs not cleared by reset");
  // ----------------------------------------
  // output run shape
  // ----------------------------------------
  property p_run_start;
    @(posedge clk) disable iff (!rstn) $rose(run_active) |-> !timer_out;
  endproperty
  a_run_start: assert property (p_run_start)
    else $error("run began with output high");
  property p_out_lead;
    @(posedge clk) disable iff (!rstn)
      $rose(timer_out) |-> run_active && $past(run_active);
  endproperty
  a_out_lead: assert property (p_out_lead)
    else $error("output high without a low delay first");
  property p_run_end;
    @(posedge clk) disable iff (!rstn) $fell(run_active) |=> !timer_out;
  endproperty
  a_run_end: assert property (p_run_end)
    else $error("output high after run ended");
endmodule

bind tto_front tto_front_monitor tto_front_monitor_inst (
  .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer_out(timer_out),
  .run_active(run_active));

// *** testbench/tto_far_side.sv ***
/*
  Model of the trigger sources: io lines, encoder pulses, other timers.
  Assumes its tasks are entered just after a rising edge of clk.
*/
`timescale 1ns/1ps

module tto_far_side (
  input wire logic clk,
  output logic [19:0] io_line_inputs,
  output logic [19:0] io_line_is_output,
  output logic encoder_pulse_a,
  output logic encoder_pulse_b,
  output logic [3:0] other_timer_outputs
);
  initial begin
    io_line_inputs = 20'h0;
    io_line_is_output = 20'h0;
    encoder_pulse_a = 1'b0;
    encoder_pulse_b = 1'b0;
    other_timer_outputs = 4'h0;
  end
  // kind 0 io line, 1 encoder a, 2 other timer, 3 encoder b
  task automatic set(int kind, int idx, logic v);
    if (kind == 0) io_line_inputs[idx] <= v;
    else if (kind == 1) encoder_pulse_a <= v;
    else if (kind == 3) encoder_pulse_b <= v;
    else other_timer_outputs[idx] <= v;
  endtask
  task automatic pulse(int kind, int idx, int w);
    set(kind, idx, 1'b1);
    repeat (w) @(posedge clk);
    set(kind, idx, 1'b0);
    repeat (w) @(posedge clk);
  endtask
  task automatic set_dir(int idx, logic out);
    io_line_is_output[idx] <= out;
  endtask
endmodule

// *** testbench/tto_front_tb_top.sv ***
/*
  Self-checking bench of tto_front with the trigger source model.
  Assumes the package and parameter header compiled before it.
*/
`timescale 1ns/1ps
`include "tto_params.svh"

module tto_front_tb_top;
  import tto_pkg::*;
  typedef struct {logic [7:0] adr; logic [31:0] exp;} tto_row_type;
  logic clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic timer_out, run_active, encoder_pulse_a, encoder_pulse_b;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, other_timer_outputs;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [19:0] io_line_inputs, io_line_is_output;
  int fail_count = 0;
  int samples_checked = 0;
  tto_row_type rows [11] = '{'{`TTO_OFS_CTRL, 32'h0},
    '{`TTO_OFS_ORIGIN, 32'h0002_0000}, '{`TTO_OFS_PRESCALE, 32'h1},
    '{`TTO_OFS_CMD, 32'h0}, '{`TTO_OFS_LEN0, 32'h1},
    '{`TTO_OFS_LEN1, 32'h1}, '{`TTO_OFS_LEN2, 32'h1},
    '{`TTO_OFS_LEN3, 32'h1}, '{`TTO_OFS_TALLY, 32'h0},
    '{`TTO_OFS_STATUS, 32'h8}, '{8'h30, 32'h0}};

  tto_front #(.NUM_LINES(20), .NUM_TIMERS(4), .OWN_TIMER(2'h0), .PW(16))
  tto_front_inst (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .io_line_inputs(io_line_inputs),
    .io_line_is_output(io_line_is_output),
    .encoder_pulse_a(encoder_pulse_a), .encoder_pulse_b(encoder_pulse_b),
    .other_timer_outputs(other_timer_outputs), .timer_out(timer_out),
    .run_active(run_active));
  tto_far_side tto_far_side_inst (.clk(clk),
    .io_line_inputs(io_line_inputs), .io_line_is_output(io_line_is_output),
    .encoder_pulse_a(encoder_pulse_a), .encoder_pulse_b(encoder_pulse_b),
    .other_timer_outputs(other_timer_outputs));

  // ----------------------------------------
  // clock, watchdog, shared tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    conclude();
  end
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wb_xfer(logic we, logic [7:0] adr, logic [31:0] d,
                         output logic [31:0] q);
    int w;
    w = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      w++;
    end while (wb_ack_o !== 1'b1 && w < 50);
    if (w >= 50) fail_count++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(logic [7:0] adr, logic [31:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, adr, d, q);
  endtask
  task automatic rd_check(logic [7:0] adr, logic [31:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, adr, 32'h0, q);
    check(q, exp);
  endtask
  // cycles of one unbroken run, output sampled mid-phase
  task automatic run_len(output int n, output logic [3:0] pat);
    int w;
    n = 0;
    w = 0;
    pat = 4'h0;
    while (run_active !== 1'b1 && w < 2000) begin
      @(posedge clk);
      w++;
    end
    while (run_active === 1'b1 && n < 5000) begin
      if (n % 100 == 50) pat[(n / 100) % 4] = timer_out;
      @(posedge clk);
      n++;
    end
  endtask
  task automatic quiet(int c);
    logic seen;
    seen = 1'b0;
    repeat (c) begin
      @(posedge clk);
      seen = seen | (run_active !== 1'b0);
    end
    check({31'h0, seen}, 32'h0);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int n;
    logic [3:0] pat;
    {rstn, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h0;
    wb_adr_i = 8'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) rd_check(rows[i].adr, rows[i].exp);
    wr(`TTO_OFS_CTRL, 32'h9);
    fork
      run_len(n, pat);
      repeat (3) tto_far_side_inst.pulse(0, 0, 20);
    join
    check(n, 400);
    check(pat, 4'ha);
    rd_check(`TTO_OFS_TALLY, 32'h2);
    wr(`TTO_OFS_CTRL, 32'hb);
    fork
      run_len(n, pat);
      repeat (3) tto_far_side_inst.pulse(0, 0, 20);
    join
    check(n, 800);
    rd_check(`TTO_OFS_TALLY, 32'h3);
    wr(`TTO_OFS_CTRL, 32'hd);
    fork
      run_len(n, pat);
      begin
        tto_far_side_inst.pulse(0, 0, 20);
        repeat (160) @(posedge clk);
        tto_far_side_inst.pulse(0, 0, 20);
      end
    join
    check({31'h0, n >= 590 && n <= 610}, 32'h1);
    rd_check(`TTO_OFS_TALLY, 32'h3);
    wr(`TTO_OFS_CTRL, 32'h1);
    fork
      run_len(n, pat);
      repeat (3) tto_far_side_inst.pulse(0, 0, 20);
    join
    rd_check(`TTO_OFS_TALLY, 32'h3);
    wr(`TTO_OFS_CMD, 32'h2);
    rd_check(`TTO_OFS_TALLY, 32'h0);
    // software origin, both edges asked, prescale 2
    wr(`TTO_OFS_PRESCALE, 32'h2);
    wr(`TTO_OFS_ORIGIN, 32'h4);
    wr(`TTO_OFS_CMD, 32'h1);
    quiet(50);
    wr(`TTO_OFS_CMD, 32'h1);
    run_len(n, pat);
    check(n, 400);
    wr(`TTO_OFS_CMD, 32'h1);
    wr(`TTO_OFS_CTRL, 32'h0);
    wr(`TTO_OFS_CTRL, 32'h1);
    wr(`TTO_OFS_CMD, 32'h1);
    quiet(100);
    wr(`TTO_OFS_CTRL, 32'h0);
    wr(`TTO_OFS_PRESCALE, 32'h1);
    wr(`TTO_OFS_CTRL, 32'h3);
    wr(`TTO_OFS_CMD, 32'h1);
    wr(`TTO_OFS_CMD, 32'h1);
    // status is read at the request edge: wait for the store and first high
    repeat (100) @(posedge clk);
    rd_check(`TTO_OFS_STATUS, 32'h7 | 32'h20);
    wr(`TTO_OFS_CTRL, 32'h2);
    wr(`TTO_OFS_CTRL, 32'h3);
    rd_check(`TTO_OFS_STATUS, 32'h8);
    quiet(500);
    // own timer output must be refused
    wr(`TTO_OFS_ORIGIN, 32'h5);
    rd_check(`TTO_OFS_ORIGIN, 32'h4);
    wr(`TTO_OFS_ORIGIN, 32'h0002_0105);
    rd_check(`TTO_OFS_ORIGIN, 32'h0002_0105);
    fork
      run_len(n, pat);
      tto_far_side_inst.pulse(2, 1, 20);
    join
    check(n, 400);
    // encoder asked for falling edges still takes the rise only
    wr(`TTO_OFS_ORIGIN, 32'h0001_0002);
    tto_far_side_inst.set(1, 0, 1'b1);
    run_len(n, pat);
    check(n, 400);
    // the fall comes after the run, so a wrong edge would start one here
    tto_far_side_inst.set(1, 0, 1'b0);
    quiet(100);
    wr(`TTO_OFS_ORIGIN, 32'h0001_0003);
    tto_far_side_inst.set(3, 0, 1'b1);
    run_len(n, pat);
    check(n, 400);
    tto_far_side_inst.set(0, 2, 1'b1);
    tto_far_side_inst.set_dir(2, 1'b1);
    wr(`TTO_OFS_ORIGIN, 32'h0004_0200);
    repeat (20) @(posedge clk);
    check({31'h0, run_active}, 32'h1);
    wr(`TTO_OFS_ORIGIN, 32'h1);
    repeat (1000) @(posedge clk);
    check({31'h0, run_active}, 32'h1);
    repeat (437) @(posedge clk);
    check({31'h0, run_active}, 32'h1);
    // reset in mid-run
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check({31'h0, run_active}, 32'h0);
    rd_check(`TTO_OFS_ORIGIN, 32'h0002_0000);
    conclude();
  end
endmodule
